// ### src/l1_cache_pkg.sv
// constants for the l1 lookup and access attribute block
// assumes a 32-bit logical/physical address and a 10 MHz core clock
package l1_cache_pkg;
  localparam int NUM_SETS = 128;
  localparam int NUM_WAYS = 8;
  localparam int BLOCK_BYTES = 32;
  localparam int OFFSET_W = 5;
  localparam int INDEX_W = 7;
  localparam int TAG_W = 20;
  localparam int WAY_W = 3;
  localparam int DSTAT_W = 6;
  localparam int BEATS_PER_FILL = 4;
  localparam int BEAT_W = 64;
  // address bit positions, little-endian numbering (bit 31 = msb)
  localparam int OFFSET_LSB = 0;
  localparam int INDEX_LSB = 5;
  localparam int TAG_LSB = 12;
  localparam int IWORD_LSB = 2;
  // attribute field positions: {write_through, inhibit, coherent, guarded}
  localparam int ATTR_W_BIT = 3;
  localparam int ATTR_I_BIT = 2;
  localparam int ATTR_M_BIT = 1;
  localparam int ATTR_G_BIT = 0;
  localparam logic [3:0] ATTR_REAL_MODE = 4'h3;
  // apb register offsets
  localparam logic [11:0] CFG_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] HITCOUNT_OFFSET = 12'h008;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int CFG_SPD_BIT = 0;
  localparam int CFG_DINV_BIT = 1;
  localparam int CFG_IINV_BIT = 2;
  typedef enum logic [1:0] {
    GL_IDLE = 2'b00,
    GL_WAIT = 2'b01,
    GL_BUSY = 2'b10
  } guard_state_e;
endpackage

// ### src/plru_tree.sv
// tree pseudo-lru state for one set of eight ways
// assumes the caller holds one 7-bit state per set
module plru_tree
  import l1_cache_pkg::*;
(
  input wire logic [6:0] state_in,
  input wire logic [WAY_W-1:0] touch_way_in,
  output logic [6:0] next_state_out,
  output logic [WAY_W-1:0] victim_out
);
  // node 0 root, 1..2 level one, 3..6 leaves; bit=1 means victim to the right
  wire logic v0 = state_in[0];
  wire logic v1 = v0 ? state_in[2] : state_in[1];
  wire logic [2:0] lnode = {1'b0, v0, v1} + 3'h3;
  wire logic v2 = state_in[lnode];
  assign victim_out = {v0, v1, v2};

  wire logic t0 = touch_way_in[2];
  wire logic t1 = touch_way_in[1];
  wire logic [2:0] mnode = t0 ? 3'h2 : 3'h1;
  wire logic [2:0] tnode = {1'b0, t0, t1} + 3'h3;
  always_comb begin
    next_state_out = state_in;
    // point each node on the touched path away from it
    next_state_out[0] = ~t0;
    next_state_out[mnode] = ~t1;
    next_state_out[tnode] = ~touch_way_in[0];
  end
endmodule

// ### src/l1_cache_lookup.sv
// split l1 tag lookup, attribute generation and guarded load ordering
// assumes lsu, fetch unit and biu on the same clock; data arrays live outside
// Functional notes
// - data cache is 128 sets of eight ways
// - block holds 32 bytes, six status bits, tag
// - low five address bits are byte offset
// - next seven bits index the set
// - tag is upper twenty physical bits, compared
// - set read with translation, tag compare after
// - data tags have independent lsu and snoop ports
// - icache 128x8 blocks, one valid bit each
// - three bits above byte select instruction word
// - icache ignores snoops; only invalidation clears
// - aliases only for non-coherent cacheable attributes
// - translation off gives write-back cacheable coherent guarded
// - coherency attribute picks global bus transaction
// - block-translated instruction accesses are never guarded
// - guarded reads out of order only if certain
// - speculative disable blocks non-guarded out-of-order access
// - guarded load waits until oldest and drained
// - refill in four 64-bit beats, critical first
// - victim way chosen by pseudo lru
module l1_cache_lookup
  import l1_cache_pkg::*;
(
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // data lookup from lsu, address given at cycle 0, physical tag at cycle 1
  input wire logic D_REQ_IN,
  input wire logic [31:0] D_EA_IN,
  input wire logic [TAG_W-1:0] D_PA_TAG_IN,
  input wire logic DATA_TRANSLATE_ENABLE_IN,
  input wire logic [3:0] D_ATTR_IN,
  output logic D_HIT_OUT,
  output logic D_MISS_OUT,
  output logic [WAY_W-1:0] D_WAY_OUT,
  output logic [OFFSET_W-1:0] D_BYTE_OUT,
  output logic [DSTAT_W-1:0] D_STATUS_OUT,
  output logic [3:0] D_ATTR_OUT,
  output logic D_ALIAS_ERR_OUT,
  output logic D_GLOBAL_OUT,
  output logic [WAY_W-1:0] D_VICTIM_OUT,
  output logic [1:0] D_FILL_FIRST_BEAT_OUT,
  // snoop lookup, second tag port
  input wire logic S_REQ_IN,
  input wire logic [31:0] S_PA_IN,
  input wire logic S_INVALIDATE_IN,
  output logic S_HIT_OUT,
  output logic [DSTAT_W-1:0] S_STATUS_OUT,
  // data refill from biu
  input wire logic D_FILL_IN,
  input wire logic [31:0] D_FILL_PA_IN,
  input wire logic [WAY_W-1:0] D_FILL_WAY_IN,
  input wire logic [DSTAT_W-1:0] D_FILL_STATUS_IN,
  // instruction lookup
  input wire logic I_REQ_IN,
  input wire logic [31:0] I_EA_IN,
  input wire logic [TAG_W-1:0] I_PA_TAG_IN,
  input wire logic INSTR_TRANSLATE_ENABLE_IN,
  input wire logic INSTR_BLOCK_TRANSLATION_PAIR_IN,
  input wire logic [3:0] I_ATTR_IN,
  output logic I_HIT_OUT,
  output logic I_MISS_OUT,
  output logic [WAY_W-1:0] I_WAY_OUT,
  output logic [2:0] I_WORD_OUT,
  output logic [3:0] I_ATTR_OUT,
  output logic [WAY_W-1:0] I_VICTIM_OUT,
  output logic [1:0] I_FILL_FIRST_BEAT_OUT,
  input wire logic I_FILL_IN,
  input wire logic [31:0] I_FILL_PA_IN,
  input wire logic [WAY_W-1:0] I_FILL_WAY_IN,
  input wire logic I_INVALIDATE_IN,
  input wire logic [31:0] I_INVALIDATE_PA_IN,
  // out-of-order and guarded load control
  input wire logic LOAD_REQ_IN,
  input wire logic LOAD_GUARDED_IN,
  input wire logic LOAD_SPECULATIVE_IN,
  input wire logic LOAD_OLDEST_IN,
  input wire logic [3:0] LOADS_OUTSTANDING_IN,
  input wire logic LOAD_DONE_IN,
  output logic LOAD_ISSUE_OUT,
  output logic LOAD_BLOCKED_OUT,
  input wire logic I_PREFETCH_REQ_IN,
  input wire logic I_PREFETCH_GUARDED_IN,
  output logic I_PREFETCH_ALLOW_OUT
);
  import l1_cache_pkg::*;

  // tag arrays: flops indexed by set and way
  logic [TAG_W-1:0] dtag [NUM_SETS][NUM_WAYS];
  logic [DSTAT_W-1:0] dstat [NUM_SETS][NUM_WAYS];
  logic [TAG_W-1:0] itag [NUM_SETS][NUM_WAYS];
  logic [NUM_WAYS-1:0] ival [NUM_SETS];
  logic [6:0] dlru [NUM_SETS];
  logic [6:0] ilru [NUM_SETS];

  // address split
  wire logic [INDEX_W-1:0] d_index = D_EA_IN[INDEX_LSB +: INDEX_W];
  wire logic [INDEX_W-1:0] i_index = I_EA_IN[INDEX_LSB +: INDEX_W];
  wire logic [INDEX_W-1:0] s_index = S_PA_IN[INDEX_LSB +: INDEX_W];
  wire logic [TAG_W-1:0] s_tag = S_PA_IN[TAG_LSB +: TAG_W];
  wire logic [INDEX_W-1:0] df_index = D_FILL_PA_IN[INDEX_LSB +: INDEX_W];
  wire logic [INDEX_W-1:0] if_index = I_FILL_PA_IN[INDEX_LSB +: INDEX_W];
  wire logic [INDEX_W-1:0] ii_index = I_INVALIDATE_PA_IN[INDEX_LSB +: INDEX_W];
  wire logic [TAG_W-1:0] ii_tag = I_INVALIDATE_PA_IN[TAG_LSB +: TAG_W];

  // apb registers
  logic [31:0] cfg;
  logic [31:0] hit_count;
  wire logic speculative_access_disable = cfg[CFG_SPD_BIT];

  // stage 1 holds the set chosen from the untranslated index
  logic d_req_q, i_req_q;
  logic [INDEX_W-1:0] d_index_q, i_index_q;
  logic [OFFSET_W-1:0] d_byte_q;
  logic [2:0] i_word_q;
  logic [1:0] d_dw_q, i_dw_q;
  logic [3:0] d_attr_q, i_attr_q;

  // attribute generation
  logic [3:0] d_attr_eff, i_attr_eff;
  always_comb begin
    d_attr_eff = DATA_TRANSLATE_ENABLE_IN ? D_ATTR_IN : ATTR_REAL_MODE;
    i_attr_eff = INSTR_TRANSLATE_ENABLE_IN ? I_ATTR_IN : ATTR_REAL_MODE;
    if (INSTR_TRANSLATE_ENABLE_IN && INSTR_BLOCK_TRANSLATION_PAIR_IN) begin
      i_attr_eff[ATTR_G_BIT] = 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      d_req_q <= 1'b0;
      i_req_q <= 1'b0;
      d_index_q <= '0;
      i_index_q <= '0;
      d_byte_q <= '0;
      i_word_q <= '0;
      d_dw_q <= '0;
      i_dw_q <= '0;
      d_attr_q <= '0;
      i_attr_q <= '0;
    end else begin
      d_req_q <= D_REQ_IN;
      i_req_q <= I_REQ_IN;
      d_index_q <= d_index;
      i_index_q <= i_index;
      d_byte_q <= D_EA_IN[OFFSET_LSB +: OFFSET_W];
      i_word_q <= I_EA_IN[IWORD_LSB +: 3];
      d_dw_q <= D_EA_IN[4:3];
      i_dw_q <= I_EA_IN[4:3];
      d_attr_q <= d_attr_eff;
      i_attr_q <= i_attr_eff;
    end
  end

  // stage 2: physical tag compare across all ways
  logic [NUM_WAYS-1:0] d_match, i_match, s_match, ii_match;
  genvar w;
  generate
    for (w = 0; w < NUM_WAYS; w++) begin : g_way
      assign d_match[w] = dstat[d_index_q][w][0] && dtag[d_index_q][w] == D_PA_TAG_IN;
      assign i_match[w] = ival[i_index_q][w] && itag[i_index_q][w] == I_PA_TAG_IN;
      assign s_match[w] = dstat[s_index][w][0] && dtag[s_index][w] == s_tag;
      assign ii_match[w] = ival[ii_index][w] && itag[ii_index][w] == ii_tag;
    end
  endgenerate

  function automatic logic one_hot(input logic [NUM_WAYS-1:0] v);
    one_hot = (v != '0) && ((v & (v - 8'h01)) == '0);
  endfunction

  function automatic logic [WAY_W-1:0] enc(input logic [NUM_WAYS-1:0] v);
    enc = '0;
    for (int k = 0; k < NUM_WAYS; k++) begin
      if (v[k]) begin
        enc = WAY_W'(k);
      end
    end
  endfunction

  wire logic d_hit = d_req_q && one_hot(d_match);
  wire logic i_hit = i_req_q && one_hot(i_match);
  wire logic s_hit = S_REQ_IN && one_hot(s_match);
  wire logic [WAY_W-1:0] d_way = enc(d_match);
  wire logic [WAY_W-1:0] i_way = enc(i_match);
  wire logic [WAY_W-1:0] s_way = enc(s_match);
  wire logic [WAY_W-1:0] ii_way = enc(ii_match);

  // pseudo lru per set, one shared updater per cache
  logic [6:0] d_lru_next, i_lru_next;
  logic [WAY_W-1:0] d_victim, i_victim;
  plru_tree u_dlru (
    .state_in(dlru[d_index_q]),
    .touch_way_in(D_FILL_IN ? D_FILL_WAY_IN : d_way),
    .next_state_out(d_lru_next),
    .victim_out(d_victim)
  );
  plru_tree u_ilru (
    .state_in(ilru[i_index_q]),
    .touch_way_in(I_FILL_IN ? I_FILL_WAY_IN : i_way),
    .next_state_out(i_lru_next),
    .victim_out(i_victim)
  );
  wire logic [INDEX_W-1:0] d_lru_idx = D_FILL_IN ? df_index : d_index_q;
  wire logic [INDEX_W-1:0] i_lru_idx = I_FILL_IN ? if_index : i_index_q;

  // array updates; snoop invalidation uses the second port alongside lsu
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        dlru[s] <= '0;
        ilru[s] <= '0;
        ival[s] <= '0;
        for (int k = 0; k < NUM_WAYS; k++) begin
          dtag[s][k] <= '0;
          dstat[s][k] <= '0;
          itag[s][k] <= '0;
        end
      end
    end else begin
      if (cfg[CFG_DINV_BIT]) begin
        for (int s = 0; s < NUM_SETS; s++) begin
          for (int k = 0; k < NUM_WAYS; k++) begin
            dstat[s][k] <= '0;
          end
        end
      end else begin
        if (s_hit && S_INVALIDATE_IN) begin
          dstat[s_index][s_way] <= '0;
        end
        if (D_FILL_IN) begin
          dtag[df_index][D_FILL_WAY_IN] <= D_FILL_PA_IN[TAG_LSB +: TAG_W];
          dstat[df_index][D_FILL_WAY_IN] <= D_FILL_STATUS_IN;
        end
      end
      // snoops never reach the instruction tags
      if (cfg[CFG_IINV_BIT]) begin
        for (int s = 0; s < NUM_SETS; s++) begin
          ival[s] <= '0;
        end
      end else begin
        if (I_INVALIDATE_IN && one_hot(ii_match)) begin
          ival[ii_index][ii_way] <= 1'b0;
        end
        if (I_FILL_IN) begin
          itag[if_index][I_FILL_WAY_IN] <= I_FILL_PA_IN[TAG_LSB +: TAG_W];
          ival[if_index][I_FILL_WAY_IN] <= 1'b1;
        end
      end
      if (D_FILL_IN || d_hit) begin
        dlru[d_lru_idx] <= d_lru_next;
      end
      if (I_FILL_IN || i_hit) begin
        ilru[i_lru_idx] <= i_lru_next;
      end
    end
  end

  // alias check: a coherent cacheable attribute cannot be shared
  wire logic d_alias_bad = !d_attr_q[ATTR_I_BIT] && d_attr_q[ATTR_M_BIT];

  // lookup results registered
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      D_HIT_OUT <= 1'b0;
      D_MISS_OUT <= 1'b0;
      D_WAY_OUT <= '0;
      D_BYTE_OUT <= '0;
      D_STATUS_OUT <= '0;
      D_ATTR_OUT <= '0;
      D_ALIAS_ERR_OUT <= 1'b0;
      D_GLOBAL_OUT <= 1'b0;
      D_VICTIM_OUT <= '0;
      D_FILL_FIRST_BEAT_OUT <= '0;
      I_HIT_OUT <= 1'b0;
      I_MISS_OUT <= 1'b0;
      I_WAY_OUT <= '0;
      I_WORD_OUT <= '0;
      I_ATTR_OUT <= '0;
      I_VICTIM_OUT <= '0;
      I_FILL_FIRST_BEAT_OUT <= '0;
      S_HIT_OUT <= 1'b0;
      S_STATUS_OUT <= '0;
    end else begin
      D_HIT_OUT <= d_hit;
      D_MISS_OUT <= d_req_q && !d_hit;
      D_WAY_OUT <= d_way;
      D_BYTE_OUT <= d_byte_q;
      D_STATUS_OUT <= d_hit ? dstat[d_index_q][d_way] : '0;
      D_ATTR_OUT <= d_attr_q;
      D_ALIAS_ERR_OUT <= d_req_q && d_alias_bad && d_match != '0 && !d_hit;
      D_GLOBAL_OUT <= d_req_q && d_attr_q[ATTR_M_BIT];
      D_VICTIM_OUT <= d_victim;
      D_FILL_FIRST_BEAT_OUT <= d_dw_q;
      I_HIT_OUT <= i_hit;
      I_MISS_OUT <= i_req_q && !i_hit;
      I_WAY_OUT <= i_way;
      I_WORD_OUT <= i_word_q;
      I_ATTR_OUT <= i_attr_q;
      I_VICTIM_OUT <= i_victim;
      I_FILL_FIRST_BEAT_OUT <= i_dw_q;
      S_HIT_OUT <= s_hit;
      S_STATUS_OUT <= s_hit ? dstat[s_index][s_way] : '0;
    end
  end

  // guarded load ordering toward the system interface
  guard_state_e gstate, next_gstate;
  wire logic drained = LOADS_OUTSTANDING_IN == 4'h0;
  wire logic g_ok = LOAD_OLDEST_IN && drained;
  // speculative loads: guarded only if certain; unguarded only when spd clear
  wire logic spec_block = LOAD_SPECULATIVE_IN && (LOAD_GUARDED_IN || speculative_access_disable);
  always_comb begin
    next_gstate = gstate;
    case (gstate)
      GL_IDLE: begin
        if (LOAD_REQ_IN && LOAD_GUARDED_IN && !spec_block) begin
          next_gstate = g_ok ? GL_BUSY : GL_WAIT;
        end
      end
      GL_WAIT: begin
        if (!LOAD_REQ_IN) begin
          next_gstate = GL_IDLE;
        end else if (g_ok) begin
          next_gstate = GL_BUSY;
        end
      end
      GL_BUSY: begin
        if (LOAD_DONE_IN) begin
          next_gstate = GL_IDLE;
        end
      end
      default: next_gstate = GL_IDLE;
    endcase
  end
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      gstate <= GL_IDLE;
    end else begin
      gstate <= next_gstate;
    end
  end
  wire logic g_go = gstate != GL_BUSY && g_ok && !spec_block;
  // a guarded load in flight blocks every other load from issuing
  wire logic issue_ok = LOAD_GUARDED_IN ? g_go : (gstate != GL_BUSY && !spec_block);
  assign LOAD_ISSUE_OUT = LOAD_REQ_IN && issue_ok;
  assign LOAD_BLOCKED_OUT = LOAD_REQ_IN && !issue_ok;
  assign I_PREFETCH_ALLOW_OUT = I_PREFETCH_REQ_IN && !I_PREFETCH_GUARDED_IN && !speculative_access_disable;

  // apb slave, zero wait states
  wire logic apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  wire logic sel_cfg = PADDR_IN == CFG_OFFSET;
  wire logic sel_status = PADDR_IN == STATUS_OFFSET;
  wire logic sel_hits = PADDR_IN == HITCOUNT_OFFSET;
  wire logic mapped = sel_cfg || sel_status || sel_hits;
  wire logic [31:0] status_word = {29'h0, gstate != GL_IDLE, gstate == GL_BUSY, speculative_access_disable};
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
  assign PRDATA_OUT = sel_cfg ? cfg : sel_status ? status_word : sel_hits ? hit_count : 32'h0;

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cfg <= CFG_RESET;
      hit_count <= '0;
    end else begin
      // invalidate bits self-clear after one cycle
      cfg[CFG_DINV_BIT] <= 1'b0;
      cfg[CFG_IINV_BIT] <= 1'b0;
      if (apb_wr && sel_cfg) begin
        cfg <= PWDATA_IN & 32'h0000_0007;
      end
      if (apb_wr && sel_hits) begin
        hit_count <= PWDATA_IN;
      end else if (d_hit) begin
        hit_count <= hit_count + 32'h0000_0001;
      end
    end
  end
endmodule

// ### bench/biu_load_model.sv
// bus side model: returns data for a guarded load some cycles after issue
// assumes issue and guarded are sampled on the core clock
module biu_load_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic issue_in,
  input wire logic guarded_in,
  input wire logic slow_in,
  output logic done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // one guarded load in flight; slow mode stretches the return
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 0;
      done_out <= 1'b0;
    end else begin
      done_out <= (cnt == 1);
      if (issue_in && guarded_in && cnt == 0) begin
        cnt <= slow_in ? 6 : 1;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ### bench/l1_cache_lookup_props.sv
// port checks for the l1 lookup block
// assumes one clock and an asynchronous active-low reset
module l1_cache_lookup_props
  import l1_cache_pkg::*;
(
  input wire logic MCLK_IN, RESET_N_IN, PSEL_IN, PENABLE_IN, PSLVERR_OUT,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] D_EA_IN,
  input wire logic D_REQ_IN, DATA_TRANSLATE_ENABLE_IN, D_HIT_OUT, D_MISS_OUT,
  input wire logic D_ALIAS_ERR_OUT, D_GLOBAL_OUT, I_HIT_OUT, I_MISS_OUT,
  input wire logic INSTR_TRANSLATE_ENABLE_IN, INSTR_BLOCK_TRANSLATION_PAIR_IN,
  input wire logic [4:0] D_BYTE_OUT,
  input wire logic [3:0] D_ATTR_OUT, I_ATTR_OUT, LOADS_OUTSTANDING_IN,
  input wire logic LOAD_REQ_IN, LOAD_GUARDED_IN, LOAD_SPECULATIVE_IN,
  input wire logic LOAD_OLDEST_IN, LOAD_ISSUE_OUT
);
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  wire d_done = D_HIT_OUT || D_MISS_OUT;
  wire i_done = I_HIT_OUT || I_MISS_OUT;
  chk_apb_unmapped: assert property (PSEL_IN && PENABLE_IN && PADDR_IN > 12'h0_008 |-> PSLVERR_OUT)
    else $error("unmapped access not refused");
  chk_d_latency: assert property (D_REQ_IN |-> ##2 (D_HIT_OUT ^ D_MISS_OUT))
    else $error("lookup result late or doubled");
  chk_byte_offset: assert property (d_done |-> D_BYTE_OUT == $past(D_EA_IN[4:0], 2))
    else $error("byte offset wrong");
  chk_real_mode: assert property (d_done && !$past(DATA_TRANSLATE_ENABLE_IN, 2) |->
    D_ATTR_OUT == ATTR_REAL_MODE) else $error("real mode attributes wrong");
  chk_global_attr: assert property (d_done |-> D_GLOBAL_OUT == D_ATTR_OUT[ATTR_M_BIT])
    else $error("global flag differs from coherency attribute");
  chk_iblock_unguarded: assert property (i_done && $past(INSTR_TRANSLATE_ENABLE_IN, 2) &&
    $past(INSTR_BLOCK_TRANSLATION_PAIR_IN, 2) |-> !I_ATTR_OUT[ATTR_G_BIT])
    else $error("block translated fetch guarded");
  chk_alias_miss: assert property (D_ALIAS_ERR_OUT |-> D_MISS_OUT)
    else $error("alias error without miss");
  chk_spec_guard: assert property (LOAD_REQ_IN && LOAD_GUARDED_IN && LOAD_SPECULATIVE_IN |->
    !LOAD_ISSUE_OUT) else $error("speculative guarded load issued");
  chk_guard_order: assert property (LOAD_ISSUE_OUT && LOAD_GUARDED_IN |->
    LOAD_OLDEST_IN && LOADS_OUTSTANDING_IN == 4'h0) else $error("guarded load issued early");
endmodule

bind l1_cache_lookup l1_cache_lookup_props l1_cache_lookup_props_i (.MCLK_IN, .RESET_N_IN,
  .PSEL_IN, .PENABLE_IN, .PSLVERR_OUT, .PADDR_IN, .D_EA_IN, .D_REQ_IN, .DATA_TRANSLATE_ENABLE_IN,
  .D_HIT_OUT, .D_MISS_OUT, .D_ALIAS_ERR_OUT, .D_GLOBAL_OUT, .I_HIT_OUT, .I_MISS_OUT,
  .INSTR_TRANSLATE_ENABLE_IN, .INSTR_BLOCK_TRANSLATION_PAIR_IN, .D_BYTE_OUT, .D_ATTR_OUT,
  .I_ATTR_OUT, .LOADS_OUTSTANDING_IN, .LOAD_REQ_IN, .LOAD_GUARDED_IN, .LOAD_SPECULATIVE_IN,
  .LOAD_OLDEST_IN, .LOAD_ISSUE_OUT);

// ### bench/tb_l1_cache_lookup.sv
// self-checking bench: lookups, fills, snoops, attributes, guarded loads, apb
// assumes biu_load_model answers guarded loads
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module tb_l1_cache_lookup;
  timeunit 1ns;
  timeprecision 1ns;
  import l1_cache_pkg::*;
  logic MCLK_IN = 0, RESET_N_IN = 0, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0, D_REQ_IN = 0;
  logic DATA_TRANSLATE_ENABLE_IN = 0, S_REQ_IN = 0, S_INVALIDATE_IN = 0, D_FILL_IN = 0;
  logic I_REQ_IN = 0, INSTR_TRANSLATE_ENABLE_IN = 0, INSTR_BLOCK_TRANSLATION_PAIR_IN = 0;
  logic I_FILL_IN = 0, I_INVALIDATE_IN = 0, LOAD_REQ_IN = 0, LOAD_GUARDED_IN = 0, slow = 0;
  logic LOAD_SPECULATIVE_IN = 0, LOAD_OLDEST_IN = 0, I_PREFETCH_REQ_IN = 0;
  logic I_PREFETCH_GUARDED_IN = 0, LOAD_DONE_IN;
  logic [11:0] PADDR_IN = '0;
  logic [31:0] PWDATA_IN = '0, D_EA_IN = '0, S_PA_IN = '0, D_FILL_PA_IN = '0, I_EA_IN = '0;
  logic [31:0] I_FILL_PA_IN = '0, I_INVALIDATE_PA_IN = '0, PRDATA_OUT;
  logic [TAG_W-1:0] D_PA_TAG_IN = '0, I_PA_TAG_IN = '0;
  logic [3:0] D_ATTR_IN = '0, I_ATTR_IN = '0, LOADS_OUTSTANDING_IN = '0, D_ATTR_OUT, I_ATTR_OUT;
  logic [2:0] D_FILL_WAY_IN = '0, I_FILL_WAY_IN = '0, D_WAY_OUT, I_WAY_OUT, I_WORD_OUT;
  logic [5:0] D_FILL_STATUS_IN = '0, D_STATUS_OUT, S_STATUS_OUT;
  logic PREADY_OUT, PSLVERR_OUT, D_HIT_OUT, D_MISS_OUT, D_ALIAS_ERR_OUT, D_GLOBAL_OUT, S_HIT_OUT;
  logic I_HIT_OUT, I_MISS_OUT, LOAD_ISSUE_OUT, LOAD_BLOCKED_OUT, I_PREFETCH_ALLOW_OUT;
  logic [4:0] D_BYTE_OUT;
  logic [1:0] D_FILL_FIRST_BEAT_OUT, I_FILL_FIRST_BEAT_OUT;
  int fail_count = 0, n_compared = 0, seed = 32'hcef1_6442;
  logic [22:0] dq[$];
  logic [12:0] iq[$];
  always #50 MCLK_IN = ~MCLK_IN;
  l1_cache_lookup l1_cache_lookup_i (.*, .D_VICTIM_OUT(), .I_VICTIM_OUT());
  biu_load_model biu_load_model_i (.clk_in(MCLK_IN), .rst_n_in(RESET_N_IN),
    .issue_in(LOAD_ISSUE_OUT), .guarded_in(LOAD_GUARDED_IN), .slow_in(slow),
    .done_out(LOAD_DONE_IN));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int k;
    PSEL_IN <= 1;
    PWRITE_IN <= w;
    PADDR_IN <= a;
    PWDATA_IN <= wd;
    @(posedge MCLK_IN);
    PENABLE_IN <= 1;
    for (k = 0; k < 20; k++) begin
      @(posedge MCLK_IN);
      if (PREADY_OUT === 1'b1) break;
    end
    if (k == 20) begin
      fail_count++;
      wrap_up();
    end
    rd = PRDATA_OUT;
    er = PSLVERR_OUT;
    PSEL_IN <= 0;
    PENABLE_IN <= 0;
    @(posedge MCLK_IN);
  endtask
  task automatic dlook(logic [31:0] ea, logic [19:0] tg, logic te, logic [3:0] at, logic h,
                       logic [2:0] w, logic [5:0] st, logic al);
    logic [3:0] ef;
    ef = te ? at : ATTR_REAL_MODE;
    dq.push_back({h, h ? w : 3'h0, ea[4:0], h ? st : 6'h00, ef, ef[ATTR_M_BIT], al, ea[4:3]});
    D_REQ_IN <= 1;
    D_EA_IN <= ea;
    DATA_TRANSLATE_ENABLE_IN <= te;
    D_ATTR_IN <= at;
    @(posedge MCLK_IN);
    D_REQ_IN <= 0;
    D_EA_IN <= ~ea;
    D_PA_TAG_IN <= tg;
    repeat (3) @(posedge MCLK_IN);
  endtask
  task automatic ilook(logic [31:0] ea, logic [19:0] tg, logic te, logic bp, logic [3:0] at,
                       logic h, logic [2:0] w);
    iq.push_back({h, h ? w : 3'h0, ea[4:2], !te ? ATTR_REAL_MODE : bp ? {at[3:1], 1'b0} : at,
      ea[4:3]});
    I_REQ_IN <= 1;
    I_EA_IN <= ea;
    INSTR_TRANSLATE_ENABLE_IN <= te;
    INSTR_BLOCK_TRANSLATION_PAIR_IN <= bp;
    I_ATTR_IN <= at;
    @(posedge MCLK_IN);
    I_REQ_IN <= 0;
    I_EA_IN <= ~ea;
    I_PA_TAG_IN <= tg;
    repeat (3) @(posedge MCLK_IN);
  endtask
  task automatic dfill(logic [31:0] pa, logic [2:0] w, logic [5:0] st);
    D_FILL_IN <= 1;
    D_FILL_PA_IN <= pa;
    D_FILL_WAY_IN <= w;
    D_FILL_STATUS_IN <= st;
    @(posedge MCLK_IN);
    D_FILL_IN <= 0;
    @(posedge MCLK_IN);
  endtask
  // inv selects the single-line invalidate instead of a fill
  task automatic ifill(logic [31:0] pa, logic [2:0] w, logic inv);
    I_FILL_IN <= !inv;
    I_INVALIDATE_IN <= inv;
    I_FILL_PA_IN <= pa;
    I_INVALIDATE_PA_IN <= pa;
    I_FILL_WAY_IN <= w;
    @(posedge MCLK_IN);
    I_FILL_IN <= 0;
    I_INVALIDATE_IN <= 0;
    @(posedge MCLK_IN);
  endtask
  task automatic snoop(logic [31:0] pa, logic e, logic [5:0] st);
    S_REQ_IN <= 1;
    S_INVALIDATE_IN <= 1;
    S_PA_IN <= pa;
    @(posedge MCLK_IN);
    S_REQ_IN <= 0;
    S_INVALIDATE_IN <= 0;
    S_PA_IN <= ~pa;
    @(negedge MCLK_IN);
    `CHK("snoop_hit", e, S_HIT_OUT);
    `CHK("snoop_status", st, S_STATUS_OUT);
    @(posedge MCLK_IN);
  endtask
  task automatic ld(logic g, logic s, logic o, logic [3:0] n, logic e, logic p);
    LOAD_REQ_IN <= 1;
    LOAD_GUARDED_IN <= g;
    LOAD_SPECULATIVE_IN <= s;
    LOAD_OLDEST_IN <= o;
    LOADS_OUTSTANDING_IN <= n;
    I_PREFETCH_REQ_IN <= 1;
    I_PREFETCH_GUARDED_IN <= g;
    @(negedge MCLK_IN);
    `CHK("load_issue", e, LOAD_ISSUE_OUT);
    `CHK("load_blocked", !e, LOAD_BLOCKED_OUT);
    `CHK("prefetch_allow", p, I_PREFETCH_ALLOW_OUT);
    @(posedge MCLK_IN);
  endtask
  // results stand one cycle; compare each against the oldest note
  always @(negedge MCLK_IN) begin
    if (D_HIT_OUT === 1'b1 || D_MISS_OUT === 1'b1) begin
      if (dq.size() == 0) `CHK("d_unexpected", 1, 0);
      else `CHK("d_lookup", dq.pop_front(), {D_HIT_OUT, D_HIT_OUT ? D_WAY_OUT : 3'h0, D_BYTE_OUT,
        D_HIT_OUT ? D_STATUS_OUT : 6'h00, D_ATTR_OUT, D_GLOBAL_OUT, D_ALIAS_ERR_OUT,
        D_FILL_FIRST_BEAT_OUT});
    end
    if (I_HIT_OUT === 1'b1 || I_MISS_OUT === 1'b1) begin
      if (iq.size() == 0) `CHK("i_unexpected", 1, 0);
      else `CHK("i_lookup", iq.pop_front(), {I_HIT_OUT, I_HIT_OUT ? I_WAY_OUT : 3'h0,
        I_WORD_OUT, I_ATTR_OUT, I_FILL_FIRST_BEAT_OUT});
    end
  end
  initial begin
    logic [31:0] pa, pb, pc, ea, rd;
    logic [5:0] st;
    logic er;
    int i;
    repeat (5) @(posedge MCLK_IN);
    RESET_N_IN <= 1;
    @(posedge MCLK_IN);
    apb(0, CFG_OFFSET, 32'h0, rd, er);
    `CHK("cfg_reset", CFG_RESET, rd);
    apb(1, HITCOUNT_OFFSET, 32'h0, rd, er);
    apb(1, 12'h0_010, 32'hffff_ffff, rd, er);
    `CHK("unmapped_err", 1, er);
    apb(0, 12'h0_010, 32'h0, rd, er);
    `CHK("unmapped_rd", 0, rd);
    $display("registers done");
    for (i = 0; i < 8; i++) begin
      pa = $random(seed);
      ea = $random(seed);
      ea[11:0] = pa[11:0];
      st = 6'($random(seed)) | 6'h01;
      dfill(pa, 3'(i), st);
      dlook(ea, pa[31:12], i[0], 4'(i * 3), 1, 3'(i), st, 0);
      dlook(ea, ~pa[31:12], 1, 4'(i), 0, 0, 0, 0);
      ifill(pa, 3'(7 - i), 0);
      ilook(ea, pa[31:12], i[1], i[0], 4'(i * 5), 1, 3'(7 - i));
    end
    apb(0, HITCOUNT_OFFSET, 32'h0, rd, er);
    `CHK("hit_count", 8, rd);
    $display("lookups done");
    pa = $random(seed);
    pb = pa ^ 32'h0010_0000;
    pc = pa ^ 32'h0020_0000;
    dfill(pa, 0, 6'h01);
    dfill(pa, 1, 6'h01);
    dfill(pb, 2, 6'h03);
    dfill(pc, 3, 6'h01);
    ifill(pc, 4, 0);
    dlook(pa, pa[31:12], 1, 4'b0010, 0, 0, 0, 1);
    dlook(pa, pa[31:12], 1, 4'b1000, 0, 0, 0, 0);
    fork
      dlook(pb, pb[31:12], 1, 4'h0, 1, 2, 6'h03, 0);
      snoop(pc, 1, 6'h01);
    join
    dlook(pc, pc[31:12], 1, 4'h0, 0, 0, 0, 0);
    ilook(pc, pc[31:12], 1, 0, 4'h0, 1, 4);
    ifill(pc, 0, 1);
    ilook(pc, pc[31:12], 1, 0, 4'h0, 0, 0);
    ifill(pb, 6, 0);
    apb(1, CFG_OFFSET, 32'h0000_0006, rd, er);
    apb(0, CFG_OFFSET, 32'h0, rd, er);
    `CHK("cfg_selfclear", 0, rd);
    dlook(pb, pb[31:12], 1, 4'h0, 0, 0, 0, 0);
    ilook(pb, pb[31:12], 1, 0, 4'h0, 0, 0);
    $display("alias snoop invalidate done");
    for (i = 0; i < 2; i++) begin
      slow <= i[0];
      ld(1, 0, 0, 4'h0, 0, 0);
      ld(1, 0, 1, 4'h2, 0, 0);
      ld(1, 0, 1, 4'h0, 1, 0);
      ld(0, 0, 1, 4'h0, 0, 1);
      // look at the done pulse mid-cycle, where it stands settled
      for (int k = 0; k < 20 && LOAD_DONE_IN !== 1'b1; k++) @(negedge MCLK_IN);
      if (LOAD_DONE_IN !== 1'b1) begin
        fail_count++;
        wrap_up();
      end
      @(posedge MCLK_IN);
      ld(0, 0, 1, 4'h0, 1, 1);
    end
    ld(1, 1, 1, 4'h0, 0, 0);
    ld(0, 1, 1, 4'h0, 1, 1);
    apb(1, CFG_OFFSET, 32'h0000_0001, rd, er);
    apb(0, STATUS_OFFSET, 32'h0, rd, er);
    `CHK("status_spd", 1, rd[CFG_SPD_BIT]);
    ld(0, 1, 1, 4'h0, 0, 0);
    LOAD_REQ_IN <= 0;
    I_PREFETCH_REQ_IN <= 0;
    $display("guarded loads done");
    `CHK("queue_drain", 0, dq.size() + iq.size());
    wrap_up();
  end
endmodule
